// ### src/timer8_pkg.sv
// Package with register map, field positions, modes and timing constants of the 8-bit timer.
// Operation
// - Wave mode 1 counts up bottom to max, then down, eight-bit resolution.
// - In phase correct mode the counter holds max for exactly one tick.
// - Overflow flag sets at bottom in phase correct, at max otherwise.
// - Phase correct: mode 2 clears on up match, sets on down; 3 opposite.
// - Phase correct mode 2: compare at bottom gives constant low, at max constant high; 3 opposite.
// - Output level held at max equals the up-counting match result unless compare is max.
// - A missed up-counting match still applies its output change.
// - Fully synchronous; the tick is only a clock enable.
// - Force strobe in non-PWM mode applies a compare action immediately.
// - Force strobe ignored in PWM; raises no flag, clears no counter.
// - The force strobe bit always reads as zero.
// - Mode bits 6 and 3 pick normal, phase correct, clear-on-match, fast PWM.
// - Compare writes immediate in normal and clear-on-match, buffered in PWM.
// - Nonzero compare output mode lets the waveform take over the pin.
// - Non-PWM compare mode: 0 off, 1 toggle, 2 clear, 3 set.
// - Fast PWM: mode 2 clears on match, sets at top; 3 opposite.
// - In PWM, compare equal to top with upper bit set ignores the match.
// - Tick select 0 stops, 1 undivided, 2 to 5 divide by 8..1024.
// - Tick select 6 and 7 count falling and rising external edges.
// - External edges count even when the pin is an output.
// - Phase correct period lasts 510 ticks.
// - Max is 0xff, bottom 0x00; normal mode wraps without clear.
// - Compare flag sets on match, clears on vector or written one.
package timer8_pkg;

  // Register addresses on the plain register port.
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;

  // Field positions inside the control register.
  localparam int FORCE_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int COMOUT_HI_BIT = 5;
  localparam int COMOUT_LO_BIT = 4;
  localparam int MODE_HI_BIT = 3;
  localparam int TICK_SEL_HI = 2;

  // Field positions inside the flag register.
  localparam int OVF_BIT = 0;
  localparam int CMP_BIT = 1;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;

  // Counter limits.
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // Prescaler tap divisors, as masks of a free running 10-bit prescaler.
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;

  // Phase correct period in ticks.
  localparam int PC_PERIOD_TICKS = 510;

  // Waveform modes, written as the two-bit select {bit 3, bit 6}.
  localparam logic [1:0] WAVE_NORMAL = 2'h0;
  localparam logic [1:0] WAVE_PHASE = 2'h1;
  localparam logic [1:0] WAVE_CLEAR = 2'h2;
  localparam logic [1:0] WAVE_FAST = 2'h3;

  // Compare output modes.
  localparam logic [1:0] COMOUT_OFF = 2'h0;
  localparam logic [1:0] COMOUT_TOGGLE = 2'h1;
  localparam logic [1:0] COMOUT_CLEAR = 2'h2;
  localparam logic [1:0] COMOUT_SET = 2'h3;

  // Tick source selects.
  localparam logic [2:0] TICK_STOP = 3'h0;
  localparam logic [2:0] TICK_DIV1 = 3'h1;
  localparam logic [2:0] TICK_DIV8 = 3'h2;
  localparam logic [2:0] TICK_DIV64 = 3'h3;
  localparam logic [2:0] TICK_DIV256 = 3'h4;
  localparam logic [2:0] TICK_DIV1024 = 3'h5;
  localparam logic [2:0] TICK_EXT_FALL = 3'h6;
  localparam logic [2:0] TICK_EXT_RISE = 3'h7;

endpackage

// ### src/timer8_wave.sv
// 8-bit timer/counter with waveform generator, register port and compare output.
`timescale 1ns/1ns
module timer8_wave
  import timer8_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Vector acknowledges that clear the flags.
  input wire logic ovf_vector_ack,
  input wire logic cmp_vector_ack,
  // External count pin, already synchronised to clk_sys.
  input wire logic ext_count_pin,
  // Waveform pin and its override.
  output logic wave_out,
  output logic wave_pin_override,
  // Flags, as levels.
  output logic overflow_flag,
  output logic compare_flag
);

  logic [7:0] control_q;
  logic [7:0] count_q;
  logic count_up_q;
  logic [7:0] compare_q;
  logic [7:0] compare_buf_q;
  logic [9:0] presc_q;
  logic ext_prev_q;
  logic wave_q;
  logic ovf_q;
  logic cmp_q;
  logic block_match_q;
  logic [7:0] rdata_q;
  logic override_q;

  logic [1:0] wave_mode;
  logic [1:0] comout;
  logic [2:0] tick_sel;
  logic is_pwm;
  logic timer_tick;
  logic [7:0] top_value;
  logic match;
  logic force_hit;
  logic wr_control;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;

  // Control fields; the mode select is split over bits 3 and 6.
  assign wave_mode = {control_q[MODE_HI_BIT], control_q[MODE_LO_BIT]};
  assign comout = control_q[COMOUT_HI_BIT:COMOUT_LO_BIT];
  assign tick_sel = control_q[TICK_SEL_HI:0];
  assign is_pwm = (wave_mode == WAVE_PHASE) || (wave_mode == WAVE_FAST);
  assign top_value = (wave_mode == WAVE_CLEAR) ? compare_q : COUNT_MAX;
  assign match = (count_q == compare_q) && !block_match_q;
  assign wr_control = reg_wr && (reg_addr == ADDR_CONTROL);
  assign wr_count = reg_wr && (reg_addr == ADDR_COUNT);
  assign wr_compare = reg_wr && (reg_addr == ADDR_COMPARE);
  assign wr_flags = reg_wr && (reg_addr == ADDR_FLAGS);
  // A force takes effect only in non-PWM modes, under the newly written settings.
  assign force_hit = wr_control && reg_wdata[FORCE_BIT] && !reg_wdata[MODE_LO_BIT];

  // Free running prescaler on the I/O clock.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      presc_q <= 10'h000;
    end else begin
      presc_q <= presc_q + 10'h001;
    end
  end

  // Previous level of the external count pin for edge detection.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_count_pin;
    end
  end

  // Tick selection: a one-cycle enable, never a clock.
  always_comb begin
    unique case (tick_sel)
      TICK_STOP: timer_tick = 1'b0;
      TICK_DIV1: timer_tick = 1'b1;
      TICK_DIV8: timer_tick = (presc_q & DIV8_MASK) == DIV8_MASK;
      TICK_DIV64: timer_tick = (presc_q & DIV64_MASK) == DIV64_MASK;
      TICK_DIV256: timer_tick = (presc_q & DIV256_MASK) == DIV256_MASK;
      TICK_DIV1024: timer_tick = (presc_q & DIV1024_MASK) == DIV1024_MASK;
      // Edges count regardless of the pin's direction.
      TICK_EXT_FALL: timer_tick = ext_prev_q && !ext_count_pin;
      TICK_EXT_RISE: timer_tick = !ext_prev_q && ext_count_pin;
    endcase
  end

  // Control register; the force bit is a strobe and is never stored.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      control_q <= CONTROL_RESET;
    end else if (wr_control) begin
      control_q <= {1'b0, reg_wdata[6:0]};
    end
  end

  // Compare register: direct in non-PWM modes, buffered in PWM modes.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      compare_buf_q <= COMPARE_RESET;
    end else if (wr_compare) begin
      compare_buf_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      compare_q <= COMPARE_RESET;
    end else if (!is_pwm) begin
      compare_q <= wr_compare ? reg_wdata : compare_buf_q;
    end else if (timer_tick && wave_mode == WAVE_PHASE && count_q == COUNT_MAX) begin
      compare_q <= compare_buf_q;
    end else if (timer_tick && wave_mode == WAVE_FAST && count_q == COUNT_MAX) begin
      compare_q <= compare_buf_q;
    end
  end

  // Counter and direction.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_q <= COUNT_RESET;
      count_up_q <= 1'b1;
    end else if (wr_count) begin
      count_q <= reg_wdata;
    end else if (timer_tick) begin
      if (wave_mode == WAVE_PHASE) begin
        // Up to max, one tick at max, then down to bottom.
        if (count_up_q) begin
          if (count_q == COUNT_MAX) begin
            count_up_q <= 1'b0;
            count_q <= count_q - 8'h01;
          end else begin
            count_q <= count_q + 8'h01;
          end
        end else if (count_q == COUNT_BOTTOM) begin
          count_up_q <= 1'b1;
          count_q <= count_q + 8'h01;
        end else begin
          count_q <= count_q - 8'h01;
        end
      end else begin
        count_up_q <= 1'b1;
        // Clear on match at the compare top; plain wrap elsewhere.
        if (wave_mode == WAVE_CLEAR && count_q == top_value) begin
          count_q <= COUNT_BOTTOM;
        end else begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  // A count write blocks the match for the following tick.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      block_match_q <= 1'b0;
    end else if (wr_count) begin
      block_match_q <= 1'b1;
    end else if (timer_tick) begin
      block_match_q <= 1'b0;
    end
  end

  // Waveform generator.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wave_q <= 1'b0;
    end else if (force_hit) begin
      // Forced action uses the compare mode being written.
      unique case (reg_wdata[COMOUT_HI_BIT:COMOUT_LO_BIT])
        COMOUT_OFF: wave_q <= wave_q;
        COMOUT_TOGGLE: wave_q <= !wave_q;
        COMOUT_CLEAR: wave_q <= 1'b0;
        COMOUT_SET: wave_q <= 1'b1;
      endcase
    end else if (timer_tick && comout != COMOUT_OFF) begin
      if (!is_pwm) begin
        if (match) begin
          unique case (comout)
            COMOUT_OFF: wave_q <= wave_q;
            COMOUT_TOGGLE: wave_q <= !wave_q;
            COMOUT_CLEAR: wave_q <= 1'b0;
            COMOUT_SET: wave_q <= 1'b1;
          endcase
        end
      end else if (comout != COMOUT_TOGGLE) begin
        if (wave_mode == WAVE_FAST) begin
          // Top wins over a match at top.
          if (count_q == COUNT_MAX) begin
            wave_q <= !comout[0];
          end else if (match) begin
            wave_q <= comout[0];
          end
        end else if (count_q == COUNT_MAX) begin
          // Level at max is the up-match result unless compare is max.
          wave_q <= (compare_q == COUNT_MAX) ? !comout[0] : comout[0];
        end else if (count_q == COUNT_BOTTOM) begin
          // Bottom: down-match result, or constant level when compare is bottom.
          wave_q <= (compare_q == COUNT_BOTTOM) ? comout[0] : !comout[0];
        end else if (match) begin
          wave_q <= count_up_q ? comout[0] : !comout[0];
        end
      end
    end
  end

  // Overflow flag: set wins over clear.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovf_q <= 1'b0;
    end else if (timer_tick && ((wave_mode == WAVE_PHASE) ?
        (!count_up_q && count_q == COUNT_BOTTOM) : (count_q == COUNT_MAX))) begin
      ovf_q <= 1'b1;
    end else if (ovf_vector_ack || (wr_flags && reg_wdata[OVF_BIT])) begin
      ovf_q <= 1'b0;
    end
  end

  // Compare flag: set on a real match only, never on a force.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmp_q <= 1'b0;
    end else if (timer_tick && match) begin
      cmp_q <= 1'b1;
    end else if (cmp_vector_ack || (wr_flags && reg_wdata[CMP_BIT])) begin
      cmp_q <= 1'b0;
    end
  end

  // Pin override whenever a compare output mode is selected.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      override_q <= 1'b0;
    end else begin
      override_q <= (comout != COMOUT_OFF);
    end
  end

  // Read data in the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CONTROL: rdata_q <= {1'b0, control_q[6:0]};
        ADDR_COUNT: rdata_q <= count_q;
        ADDR_COMPARE: rdata_q <= compare_buf_q;
        ADDR_FLAGS: rdata_q <= {6'h00, cmp_q, ovf_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign wave_out = wave_q;
  assign wave_pin_override = override_q;
  assign overflow_flag = ovf_q;
  assign compare_flag = cmp_q;

endmodule

// ### tb/timer8_chk.sv
// Port-level assertions for the 8-bit timer, bound to its top module.
`timescale 1ns/1ns
module timer8_chk
  import timer8_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Acknowledges and pins.
  input wire logic ovf_vector_ack,
  input wire logic cmp_vector_ack,
  input wire logic ext_count_pin,
  input wire logic wave_out,
  input wire logic wave_pin_override,
  input wire logic overflow_flag,
  input wire logic compare_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // A control write, and a control write that forces a compare.
  sequence ctl_wr;
    reg_wr && reg_addr == ADDR_CONTROL;
  endsequence
  sequence force_wr;
    ctl_wr ##0 reg_wdata[FORCE_BIT] && !reg_wdata[MODE_LO_BIT];
  endsequence
  // Flag register write.
  wire flag_wr = reg_wr && reg_addr == ADDR_FLAGS;
  a_force_reads_zero: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_CONTROL
    |-> !reg_rdata[FORCE_BIT]) else $error("force strobe bit read as one");
  a_flags_read_back: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_FLAGS
    |-> reg_rdata == {6'h00, $past(compare_flag), $past(overflow_flag)})
    else $error("flag register read wrong");
  a_override_follows: assert property (ctl_wr ##1 !(reg_wr && reg_addr == ADDR_CONTROL)
    |=> wave_pin_override == (|$past(reg_wdata[COMOUT_HI_BIT:COMOUT_LO_BIT], 2)))
    else $error("pin override does not follow compare mode");
  a_force_sets_out: assert property (force_wr ##0 reg_wdata[5:4] == COMOUT_SET
    |-> ##2 wave_out) else $error("forced set missing");
  a_force_clears_out: assert property (force_wr ##0 reg_wdata[5:4] == COMOUT_CLEAR
    |-> ##2 !wave_out) else $error("forced clear missing");
  a_pwm_force_none: assert property (ctl_wr ##0 reg_wdata[FORCE_BIT]
    && reg_wdata[MODE_LO_BIT] && reg_wdata[2:0] == TICK_STOP |-> ##2 $stable(wave_out) [*2])
    else $error("force acted in pwm mode");
  a_ovf_sticky: assert property (overflow_flag && !ovf_vector_ack
    && !(flag_wr && reg_wdata[OVF_BIT]) |=> overflow_flag) else $error("overflow flag lost");
  a_cmp_sticky: assert property (compare_flag && !cmp_vector_ack
    && !(flag_wr && reg_wdata[CMP_BIT]) |=> compare_flag) else $error("compare flag lost");
endmodule

bind timer8_wave timer8_chk chk (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ovf_vector_ack(ovf_vector_ack), .cmp_vector_ack(cmp_vector_ack),
  .ext_count_pin(ext_count_pin), .wave_out(wave_out), .wave_pin_override(wave_pin_override),
  .overflow_flag(overflow_flag), .compare_flag(compare_flag));

// ### tb/testbench.sv
// Self-checking bench for the 8-bit timer with waveform output.
`timescale 1ns/1ns
module testbench
  import timer8_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ovf_vector_ack = 1'b0;
  logic cmp_vector_ack = 1'b0;
  logic ext_count_pin = 1'b0;
  logic [7:0] reg_rdata;
  logic wave_out;
  logic wave_pin_override;
  logic overflow_flag;
  logic compare_flag;
  logic [7:0] d;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  // Stimulus tables: control, compare, expected period or level.
  logic [7:0] fc [3] = '{8'hb0, 8'ha0, 8'h90};
  logic [7:0] pc [4] = '{8'h19, 8'h61, 8'h69, 8'h6a};
  logic [7:0] pv [4] = '{8'h03, 8'h80, 8'h40, 8'h40};
  int pn [4] = '{8, 510, 256, 2048};
  logic [7:0] sc [4] = '{8'h61, 8'h61, 8'h71, 8'h69};
  logic [7:0] sv [4] = '{8'h00, 8'hff, 8'h00, 8'hff};
  int dv [4] = '{8, 64, 256, 1024};

  timer8_wave uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ovf_vector_ack(ovf_vector_ack), .cmp_vector_ack(cmp_vector_ack),
    .ext_count_pin(ext_count_pin), .wave_out(wave_out), .wave_pin_override(wave_pin_override),
    .overflow_flag(overflow_flag), .compare_flag(compare_flag));

  // Clock of 20 ns period.
  initial forever #10 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Wait cycles, then step off the edge so outputs are settled.
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Cycles until the next low to high change of the waveform.
  task automatic rise(output int c);
    logic last;
    c = 0;
    last = 1'b1;
    while (c < 5000 && !(wave_out === 1'b1 && !last)) begin
      last = wave_out;
      cyc(1);
      c++;
    end
  endtask

  task automatic steady(input logic lvl, input int k);
    int bad;
    bad = 0;
    repeat (k) begin
      cyc(1);
      if (wave_out !== lvl) bad++;
    end
    check(16'(bad), 16'h0, "steady level");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run.
  initial begin
    #1600000;
    bad_count++;
    finish_test();
  end

  // Test sequence.
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      rd(3'(a));
      check(d, 16'h0, "reset value");
    end
    $display("test reset done");
    foreach (fc[i]) begin
      wr(ADDR_CONTROL, fc[i]);
      cyc(2);
      check(wave_out, i != 1, "forced level");
    end
    rd(ADDR_CONTROL);
    check(d, 16'h10, "strobe reads zero");
    check(wave_pin_override, 1, "override");
    wr(ADDR_CONTROL, 8'hf0);
    cyc(3);
    check(wave_out, 1, "force in pwm");
    check({compare_flag, overflow_flag}, 0, "force flags");
    $display("test force done");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT, 8'hf0);
    wr(ADDR_CONTROL, 8'h01);
    cyc(30);
    check(overflow_flag, 1, "overflow at max");
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT);
    check(d > 8'h00 && d < 8'h20, 1, "wrapped count");
    n = d;
    cyc(10);
    rd(ADDR_COUNT);
    check(d, 16'(n), "stopped count");
    wr(ADDR_FLAGS, 8'h01);
    check(overflow_flag, 0, "flag write clear");
    foreach (dv[i]) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CONTROL, 8'(TICK_DIV8 + i));
      cyc(10 * dv[i]);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT);
      check(d >= 8'd9 && d <= 8'd11, 1, "prescaled count");
    end
    $display("test count done");
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CONTROL, m ? 8'h06 : 8'h07);
      repeat (11) begin
        repeat (3) @(posedge clk_sys);
        ext_count_pin <= ~ext_count_pin;
      end
      cyc(4);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT);
      check(d, m ? 16'd5 : 16'd6, "external count");
      @(posedge clk_sys);
      ext_count_pin <= 1'b0;
    end
    $display("test external done");
    foreach (pc[i]) begin
      wr(ADDR_COMPARE, pv[i]);
      wr(ADDR_CONTROL, pc[i]);
      cyc(600);
      rise(n);
      rise(n);
      check(16'(n), 16'(pn[i]), "period");
    end
    wr(ADDR_CONTROL, 8'h18);
    check(compare_flag, 1, "compare flag set");
    @(posedge clk_sys);
    cmp_vector_ack <= 1'b1;
    @(posedge clk_sys);
    cmp_vector_ack <= 1'b0;
    cyc(1);
    check(compare_flag, 0, "vector clear");
    $display("test period done");
    foreach (sc[i]) begin
      wr(ADDR_COMPARE, sv[i]);
      wr(ADDR_CONTROL, sc[i]);
      cyc(600);
      steady(i != 0, 520);
    end
    wr(ADDR_CONTROL, 8'h59);
    steady(wave_out, 520);
    $display("test levels done");
    finish_test();
  end
endmodule
